// File: design/wdps_top.sv
// Watchdog with serial-memory store of output presets, Avalon-MM slave
//
// Local design decision: register access over Avalon-MM.
`include "wdps_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module wdps_top #(
  parameter int TICK_DIV = `WDPS_TICK_CYCLES,
  parameter int PORTS = 8
) (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic [9:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire wdps_pkg::wdps_bus_t avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output wdps_pkg::wdps_bus_t avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic irq_o,
  output logic nvm_cs_o,
  output logic nvm_clk_o,
  output logic nvm_serial_in_o,
  input wire logic nvm_do_i,
  output logic nvm_do_o,
  output logic nvm_do_oe_o,
  input wire logic [8*PORTS-1:0] host_port_i,
  input wire logic host_port_we_i,
  output logic [8*PORTS-1:0] isolated_output_port_o,
  output logic preset_loaded_o
);
  import wdps_pkg::*;

  localparam int WORDS = PORTS / 2;

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers

  function automatic logic hit(input logic [9:0] a, input logic [7:0] idx);
    hit = (a == {idx, 2'b00});
  endfunction : hit

  function automatic wdps_word_t merge16(input wdps_word_t old, input wdps_bus_t wd,
                                         input logic [3:0] be);
    merge16 = old;
    if (be[0]) begin
      merge16[7:0] = wd[7:0];
    end
    if (be[1]) begin
      merge16[15:8] = wd[15:8];
    end
  endfunction : merge16

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake

  logic req;
  logic wr_take;
  logic rd_cap;

  assign req = avs_read_i | avs_write_i;
  assign wr_take = avs_write_i & ~avs_waitrequest_o;
  assign rd_cap = avs_read_i & avs_waitrequest_o;

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      avs_waitrequest_o <= 1'b1;
    end else if (!avs_waitrequest_o) begin
      avs_waitrequest_o <= 1'b1;
    end else if (req) begin
      avs_waitrequest_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers

  wdps_word_t preset_lo;
  wdps_word_t preset_hi;
  logic [31:0] preset;
  logic run_en;
  logic zero_irq_enable;
  logic [3:0] nvm_line;
  wdps_word_t irq_status;
  wdps_word_t irq_mask;
  logic [31:0] countdown_value;
  logic zero_reached_flag;
  logic tick;
  logic zero_evt;
  logic load_evt;
  logic reload_request;
  logic run_start;

  assign preset = {preset_hi, preset_lo};

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      preset_lo <= 16'(`WDPS_PRESET_RST);
      preset_hi <= 16'h0000;
    end else if (wr_take) begin
      if (hit(avs_address_i, `WDPS_IDX_PRESET_LO)) begin
        preset_lo <= merge16(preset_lo, avs_writedata_i, avs_byteenable_i);
      end else if (hit(avs_address_i, `WDPS_IDX_PRESET_HI)) begin
        preset_hi <= merge16(preset_hi, avs_writedata_i, avs_byteenable_i);
      end
    end
  end

  assign run_start = wr_take & hit(avs_address_i, `WDPS_IDX_CTRL) & avs_byteenable_i[0]
                     & avs_writedata_i[`WDPS_CTL_RUN] & ~run_en;
  assign reload_request = wr_take & hit(avs_address_i, `WDPS_IDX_RELOAD) & avs_byteenable_i[0]
                          & ~avs_writedata_i[`WDPS_RELOAD_BIT];

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      run_en <= 1'b0;
      zero_irq_enable <= 1'b0;
    end else if (wr_take && hit(avs_address_i, `WDPS_IDX_CTRL) && avs_byteenable_i[0]) begin
      run_en <= avs_writedata_i[`WDPS_CTL_RUN];
      zero_irq_enable <= avs_writedata_i[`WDPS_CTL_IRQEN];
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      nvm_line <= 4'h0;
    end else if (wr_take && hit(avs_address_i, `WDPS_IDX_NVM) && avs_byteenable_i[0]) begin
      nvm_line <= avs_writedata_i[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Countdown

  wdps_tick #(
    .DIV(TICK_DIV)
  ) u_tick (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .tick_o(tick)
  );

  assign zero_reached_flag = (countdown_value == 32'h0000_0000);
  assign zero_evt = run_en & tick & (countdown_value == 32'h0000_0001) & ~reload_request;

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      countdown_value <= `WDPS_PRESET_RST;
    end else if (reload_request || run_start) begin
      countdown_value <= preset;
    end else if (run_en && tick && !zero_reached_flag) begin
      countdown_value <= countdown_value - 32'h0000_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status and mask

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_status <= 16'h0000;
    end else begin
      for (int i = 0; i < 16; i++) begin
        if (i == `WDPS_ST_ZERO && zero_evt && zero_irq_enable) begin
          irq_status[i] <= 1'b1;
        end else if (i == `WDPS_ST_LOAD && load_evt) begin
          irq_status[i] <= 1'b1;
        end else if (wr_take && hit(avs_address_i, `WDPS_IDX_STATUS) && avs_byteenable_i[i / 8]
                     && avs_writedata_i[i]) begin
          irq_status[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_mask <= `WDPS_MASK_RST;
    end else if (wr_take && hit(avs_address_i, `WDPS_IDX_MASK)) begin
      irq_mask <= merge16(irq_mask, avs_writedata_i, avs_byteenable_i);
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_status & irq_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data

  wdps_word_t rd_word;

  always_comb begin
    rd_word = 16'h0000;
    if (hit(avs_address_i, `WDPS_IDX_PRESET_LO)) begin
      rd_word = preset_lo;
    end else if (hit(avs_address_i, `WDPS_IDX_PRESET_HI)) begin
      rd_word = preset_hi;
    end else if (hit(avs_address_i, `WDPS_IDX_CTRL)) begin
      rd_word[`WDPS_CTL_RUN] = run_en;
      rd_word[`WDPS_CTL_IRQEN] = zero_irq_enable;
      rd_word[`WDPS_CTL_ZERO] = zero_reached_flag;
    end else if (hit(avs_address_i, `WDPS_IDX_NVM)) begin
      rd_word[`WDPS_NVM_DO] = nvm_do_i;
    end else if (hit(avs_address_i, `WDPS_IDX_STATUS)) begin
      rd_word = irq_status;
    end else if (hit(avs_address_i, `WDPS_IDX_MASK)) begin
      rd_word = irq_mask;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (rd_cap) begin
      avs_readdata_o <= {16'h0000, rd_word};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power-up read of the serial memory

  wdps_load_e ld_state;
  logic [2:0] ld_word;
  logic [4:0] ld_bit;
  logic ld_phase;
  wdps_word_t ld_shift;
  logic ld_cs;
  logic ld_clk;
  logic ld_di;
  logic [5:0] ld_addr;
  logic [8:0] ld_cmd;
  wdps_word_t pu_words [WORDS];
  wdps_word_t ov_words [WORDS];
  logic [8*PORTS-1:0] pu_flat;
  logic [8*PORTS-1:0] ov_flat;

  assign ld_addr = (ld_word[2] ? `WDPS_NVM_OV_BASE : `WDPS_NVM_PU_BASE) | {4'h0, ld_word[1:0]};
  assign ld_cmd = {`WDPS_NVM_READ_OP, ld_addr};
  assign load_evt = (ld_state == WDPS_LD_GAP) & tick & (ld_word == 3'(2 * WORDS - 1));

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ld_state <= WDPS_LD_BOOT;
      ld_word <= 3'h0;
      ld_bit <= 5'h00;
      ld_phase <= 1'b0;
      ld_cs <= 1'b0;
      ld_clk <= 1'b0;
      ld_di <= 1'b0;
    end else if (tick) begin
      case (ld_state)
        WDPS_LD_BOOT: begin
          ld_state <= WDPS_LD_SHIFT;
          ld_cs <= 1'b1;
          ld_bit <= 5'h00;
          ld_phase <= 1'b0;
          ld_di <= ld_cmd[8];
        end
        WDPS_LD_SHIFT: begin
          ld_phase <= ~ld_phase;
          ld_clk <= ~ld_phase;
          if (ld_phase) begin
            if (ld_bit == `WDPS_NVM_LAST_BIT) begin
              ld_state <= WDPS_LD_GAP;
              ld_cs <= 1'b0;
              ld_di <= 1'b0;
            end else begin
              ld_bit <= ld_bit + 5'h01;
              ld_di <= (ld_bit < 5'(`WDPS_NVM_CMD_BITS - 1)) ? ld_cmd[4'(7) - 4'(ld_bit)] : 1'b0;
            end
          end
        end
        WDPS_LD_GAP: begin
          if (ld_word == 3'(2 * WORDS - 1)) begin
            ld_state <= WDPS_LD_DONE;
          end else begin
            ld_word <= ld_word + 3'h1;
            ld_state <= WDPS_LD_BOOT;
          end
        end
        WDPS_LD_DONE: begin
          ld_cs <= 1'b0;
        end
        default: begin
          ld_state <= WDPS_LD_DONE;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ld_shift <= 16'h0000;
    end else if (tick && ld_state == WDPS_LD_SHIFT && ld_phase) begin
      ld_shift <= {ld_shift[14:0], nvm_do_i};
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int k = 0; k < WORDS; k++) begin
        pu_words[k] <= 16'h0000;
        ov_words[k] <= 16'h0000;
      end
    end else if (tick && ld_state == WDPS_LD_GAP) begin
      if (ld_word[2]) begin
        ov_words[ld_word[1:0]] <= ld_shift;
      end else begin
        pu_words[ld_word[1:0]] <= ld_shift;
      end
    end
  end

  // Word k carries port 2k in the low byte, port 2k+1 in the high byte
  for (genvar k = 0; k < WORDS; k++) begin : g_flat
    assign pu_flat[16*k +: 16] = pu_words[k];
    assign ov_flat[16*k +: 16] = ov_words[k];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output ports and memory pins

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      isolated_output_port_o <= '0;
    end else if (zero_evt) begin
      isolated_output_port_o <= ov_flat;
    end else if (load_evt) begin
      isolated_output_port_o <= pu_flat;
    end else if (host_port_we_i && preset_loaded_o) begin
      isolated_output_port_o <= host_port_i;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      preset_loaded_o <= 1'b0;
    end else if (load_evt) begin
      preset_loaded_o <= 1'b1;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      nvm_cs_o <= 1'b0;
      nvm_clk_o <= 1'b0;
      nvm_serial_in_o <= 1'b0;
      nvm_do_o <= 1'b0;
      nvm_do_oe_o <= 1'b0;
    end else if (!preset_loaded_o) begin
      nvm_cs_o <= ld_cs;
      nvm_clk_o <= ld_clk;
      nvm_serial_in_o <= ld_di;
      nvm_do_o <= 1'b0;
      nvm_do_oe_o <= 1'b0;
    end else begin
      nvm_cs_o <= nvm_line[`WDPS_NVM_CS];
      nvm_clk_o <= nvm_line[`WDPS_NVM_CLK];
      nvm_serial_in_o <= nvm_line[`WDPS_NVM_DI];
      nvm_do_o <= nvm_line[`WDPS_NVM_DO];
      nvm_do_oe_o <= ~nvm_line[`WDPS_NVM_CS];
    end
  end
endmodule : wdps_top
`default_nettype wire

// File: design/wdps_cfg.svh
// Offsets, field positions, reset values and timing counts of the watchdog block
`ifndef WDPS_CFG_SVH
`define WDPS_CFG_SVH
`define WDPS_IDX_PRESET_LO 8'h34
`define WDPS_IDX_PRESET_HI 8'h36
`define WDPS_IDX_CTRL 8'h38
`define WDPS_IDX_RELOAD 8'h3a
`define WDPS_IDX_NVM 8'h3c
`define WDPS_IDX_STATUS 8'h44
`define WDPS_IDX_MASK 8'h46
`define WDPS_CTL_RUN 0
`define WDPS_CTL_IRQEN 1
`define WDPS_CTL_ZERO 2
`define WDPS_RELOAD_BIT 0
`define WDPS_NVM_DO 0
`define WDPS_NVM_DI 1
`define WDPS_NVM_CLK 2
`define WDPS_NVM_CS 3
`define WDPS_ST_ZERO 0
`define WDPS_ST_LOAD 1
`define WDPS_PRESET_RST 32'h0000ffff
`define WDPS_MASK_RST 16'h0001
`define WDPS_TICK_NS 100
`define WDPS_CLK_PERIOD_PS 4000
`define WDPS_TICK_CYCLES ((`WDPS_TICK_NS * 1000) / `WDPS_CLK_PERIOD_PS)
`define WDPS_NVM_READ_OP 3'b110
`define WDPS_NVM_PU_BASE 6'h00
`define WDPS_NVM_OV_BASE 6'h10
`define WDPS_NVM_CMD_BITS 9
`define WDPS_NVM_LAST_BIT 5'h18
`endif

// File: design/wdps_pkg.sv
// Types shared by the watchdog block
package wdps_pkg;
  typedef logic [31:0] wdps_bus_t;
  typedef logic [15:0] wdps_word_t;
  typedef enum logic [3:0] {
    WDPS_LD_BOOT = 4'b0001,
    WDPS_LD_SHIFT = 4'b0010,
    WDPS_LD_GAP = 4'b0100,
    WDPS_LD_DONE = 4'b1000
  } wdps_load_e;
endpackage : wdps_pkg

// File: design/wdps_tick.sv
// Divider giving a one-cycle enable pulse every DIV clocks
`timescale 1ns/1ps
`default_nettype none
module wdps_tick #(
  parameter int DIV = 25
) (
  input wire logic clock_i,
  input wire logic rstn_i,
  output logic tick_o
);
  logic [15:0] cnt;

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt <= 16'h0000;
      tick_o <= 1'b0;
    end else if (cnt == 16'(DIV - 1)) begin
      cnt <= 16'h0000;
      tick_o <= 1'b1;
    end else begin
      cnt <= cnt + 16'h0001;
      tick_o <= 1'b0;
    end
  end
endmodule : wdps_tick
`default_nettype wire

// File: tb/wdps_top_props.sv
// Checker of bus, memory line and power-up load at the watchdog ports
`timescale 1ns/1ps
`default_nettype none
module wdps_top_props #(
  parameter int TICK_DIV = 2
) (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic [9:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire wdps_pkg::wdps_bus_t avs_writedata_i,
  input wire wdps_pkg::wdps_bus_t avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic irq_o,
  input wire logic nvm_cs_o,
  input wire logic nvm_clk_o,
  input wire logic nvm_serial_in_o,
  input wire logic nvm_do_o,
  input wire logic nvm_do_oe_o,
  input wire logic preset_loaded_o
);
  import wdps_pkg::*;
  logic wacc;
  logic racc;
  logic [15:0] lo_q;
  logic [1:0] ctl_q;
  logic [3:0] line_q;
  logic [1:0] age;
  assign wacc = avs_write_i && !avs_waitrequest_o;
  assign racc = avs_read_i && !avs_waitrequest_o;
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lo_q <= 16'hffff;
      ctl_q <= 2'h0;
    end else if (wacc && avs_address_i == 10'h0d0) begin
      lo_q <= avs_writedata_i[15:0];
    end else if (wacc && avs_address_i == 10'h0e0) begin
      ctl_q <= avs_writedata_i[1:0];
    end
  end
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      line_q <= 4'h0;
      age <= 2'h0;
    end else if (wacc && avs_address_i == 10'h0f0) begin
      line_q <= avs_writedata_i[3:0];
      age <= 2'h0;
    end else if (age != 2'h3) begin
      age <= age + 2'h1;
    end
  end
  ////////////////////////////////////////
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  a_wait_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("wait low too long");
  a_unmapped_zero: assert property (racc && !(avs_address_i inside {10'h0d0, 10'h0d8, 10'h0e0, 10'h0e8,
    10'h0f0, 10'h110, 10'h118}) |-> avs_readdata_o == 32'h0) else $error("unmapped read not zero");
  a_preset_read: assert property (racc && avs_address_i == 10'h0d0 |-> avs_readdata_o[15:0] == lo_q)
    else $error("preset low readback");
  a_ctrl_readback: assert property (racc && avs_address_i == 10'h0e0 |-> avs_readdata_o[1:0] == ctl_q)
    else $error("control readback");
  a_line_drive: assert property (age == 2'h3 && $past(preset_loaded_o, 3) |->
    {nvm_cs_o, nvm_clk_o, nvm_serial_in_o, nvm_do_o, nvm_do_oe_o} == {line_q, !line_q[3]})
    else $error("line pins differ");
  a_load_no_drive: assert property (!preset_loaded_o |-> !nvm_do_oe_o)
    else $error("data-out driven in load");
  a_load_clk_pace: assert property (!preset_loaded_o && $changed(nvm_clk_o) |=> $stable(nvm_clk_o))
    else $error("clock level too short");
  a_load_no_irq: assert property ($rose(preset_loaded_o) |-> !irq_o [*3])
    else $error("load done not masked");
  c_irq: cover property ($rose(irq_o));
  c_loaded: cover property ($rose(preset_loaded_o));
  c_zero: cover property (racc && avs_address_i == 10'h0e0 && avs_readdata_o[2]);
endmodule : wdps_top_props
bind wdps_top wdps_top_props #(.TICK_DIV(TICK_DIV)) i_wdps_top_props (.clock_i(clock_i), .rstn_i(rstn_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .irq_o(irq_o), .nvm_cs_o(nvm_cs_o), .nvm_clk_o(nvm_clk_o), .nvm_serial_in_o(nvm_serial_in_o),
  .nvm_do_o(nvm_do_o), .nvm_do_oe_o(nvm_do_oe_o), .preset_loaded_o(preset_loaded_o));
`default_nettype wire

// File: tb/wdps_nvm_model.sv
// Serial memory model answering word reads
`timescale 1ns/1ps
`default_nettype none
module wdps_nvm_model (
  input wire logic cs_i,
  input wire logic clk_i,
  input wire logic di_i,
  output logic do_o
);
  logic [15:0] mem [64];
  logic [4:0] n = 5'h0;
  logic [8:0] cmd = 9'h0;
  logic bit_q = 1'b0;
  initial begin
    for (int a = 0; a < 64; a++) begin
      mem[a] = 16'h5a3c ^ (16'(a) * 16'h0b07);
    end
  end
  always @(posedge clk_i or negedge cs_i) begin
    if (!cs_i) begin
      n <= 5'h0;
    end else begin
      if (n < 5'h19) begin
        n <= n + 5'h1;
      end
      if (n < 5'h9) begin
        cmd <= {cmd[7:0], di_i};
      end
      if (n == 5'h8) begin
        bit_q <= 1'b0;
      end else if (n > 5'h8 && n < 5'h19) begin
        bit_q <= (cmd[8:6] == 3'b110) ? mem[cmd[5:0]][5'h18 - n] : 1'b0;
      end
    end
  end
  // Released line shows the inverse of the last bit
  assign do_o = cs_i ? bit_q : !bit_q;
endmodule : wdps_nvm_model
`default_nettype wire

// File: tb/wdps_top_test.sv
// Self-checking bench of the watchdog with output preset store
`timescale 1ns/1ps
`default_nettype none
module wdps_top_test;
  import wdps_pkg::*;
  typedef struct {logic [9:0] a; logic [15:0] d; logic [15:0] e;} wdps_row_s;
  logic clock_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [9:0] avs_address_i = 10'h0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  wdps_bus_t avs_writedata_i = 32'h0;
  logic [63:0] host_port_i = 64'h0;
  logic host_port_we_i = 1'b0;
  wdps_bus_t avs_readdata_o, rdq;
  logic avs_waitrequest_o, irq_o, nvm_cs_o, nvm_clk_o, nvm_serial_in_o, nvm_do_o, nvm_do_oe_o;
  logic preset_loaded_o, mem_do, do_w;
  logic [63:0] isolated_output_port_o;
  int error_cnt = 0;
  int total_checks = 0;
  int cnt;
  logic [3:0] lv [4] = '{4'h5, 4'h4, 4'ha, 4'he};
  wdps_row_s rows [6] = '{'{10'h0d0, 16'h0005, 16'h0005}, '{10'h0d8, 16'hbeef, 16'hbeef},
    '{10'h0d8, 16'h0000, 16'h0000}, '{10'h0f8, 16'hffff, 16'h0000}, '{10'h118, 16'h0003, 16'h0003},
    '{10'h0e0, 16'h0002, 16'h0002}};
  always #2 clock_i = ~clock_i;
  assign do_w = nvm_do_oe_o ? nvm_do_o : mem_do;
  wdps_top #(.TICK_DIV(2), .PORTS(8)) i_wdps_top (.clock_i(clock_i), .rstn_i(rstn_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hf), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .irq_o(irq_o), .nvm_cs_o(nvm_cs_o), .nvm_clk_o(nvm_clk_o),
    .nvm_serial_in_o(nvm_serial_in_o), .nvm_do_i(do_w), .nvm_do_o(nvm_do_o), .nvm_do_oe_o(nvm_do_oe_o),
    .host_port_i(host_port_i), .host_port_we_i(host_port_we_i),
    .isolated_output_port_o(isolated_output_port_o), .preset_loaded_o(preset_loaded_o));
  wdps_nvm_model i_wdps_nvm_model (.cs_i(nvm_cs_o), .clk_i(nvm_clk_o), .di_i(nvm_serial_in_o), .do_o(mem_do));
  ////////////////////////////////////////
  function automatic logic [63:0] img(input int b);
    img = {i_wdps_nvm_model.mem[b+3], i_wdps_nvm_model.mem[b+2], i_wdps_nvm_model.mem[b+1], i_wdps_nvm_model.mem[b]};
  endfunction : img
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [9:0] a, input logic [15:0] d);
    avs_address_i <= a;
    avs_writedata_i <= {16'h0, d};
    avs_write_i <= w;
    avs_read_i <= !w;
    @(posedge clock_i);
    while (avs_waitrequest_o !== 1'b0) begin
      @(posedge clock_i);
    end
    rdq = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge clock_i);
  endtask : bus
  task automatic rdc(input logic [9:0] a, input logic [15:0] e);
    bus(1'b0, a, 16'h0);
    chk(rdq, e);
  endtask : rdc
  task automatic wait_load;
    for (int n = 0; n < 4000 && preset_loaded_o !== 1'b1; n++) begin
      @(posedge clock_i);
    end
    chk(preset_loaded_o, 1'b1);
    repeat (2) @(posedge clock_i);
  endtask : wait_load
  task automatic end_sim;
    if (error_cnt == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim
  task automatic run(input logic [15:0] c);
    bus(1'b1, 10'h0e0, 16'h0000);
    bus(1'b1, 10'h0e0, c);
    repeat (40) @(posedge clock_i);
  endtask : run
  ////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clock_i);
    error_cnt++;
    end_sim;
  end
  initial begin
    repeat (16) @(posedge clock_i);
    chk({avs_waitrequest_o, irq_o, preset_loaded_o, nvm_do_oe_o}, 4'h8);
    rstn_i <= 1'b1;
    host_port_i <= '1;
    host_port_we_i <= 1'b1;
    @(posedge clock_i);
    host_port_we_i <= 1'b0;
    wait_load();
    chk(isolated_output_port_o, img(0));
    rdc(10'h110, 16'h0002);
    bus(1'b1, 10'h110, 16'h0003);
    rdc(10'h110, 16'h0000);
    foreach (rows[i]) begin
      bus(1'b1, rows[i].a, rows[i].d);
      rdc(rows[i].a, rows[i].e);
    end
    bus(1'b1, 10'h0e0, 16'h0000);
    bus(1'b1, 10'h0e0, 16'h0003);
    cnt = 0;
    while (irq_o !== 1'b1 && cnt < 200) begin
      @(posedge clock_i);
      cnt++;
    end
    chk(cnt >= 8 && cnt <= 13, 1'b1);
    chk(isolated_output_port_o, img(16));
    rdc(10'h0e0, 16'h0007);
    repeat (30) @(posedge clock_i);
    rdc(10'h0e0, 16'h0007);
    rdc(10'h110, 16'h0001);
    bus(1'b1, 10'h110, 16'h0001);
    rdc(10'h110, 16'h0000);
    chk(irq_o, 1'b0);
    bus(1'b1, 10'h0e8, 16'h0001);
    rdc(10'h0e0, 16'h0007);
    bus(1'b1, 10'h0e8, 16'h0000);
    rdc(10'h0e0, 16'h0003);
    run(16'h0001);
    rdc(10'h0e0, 16'h0005);
    rdc(10'h110, 16'h0000);
    bus(1'b1, 10'h118, 16'h0002);
    run(16'h0003);
    rdc(10'h110, 16'h0001);
    chk(irq_o, 1'b0);
    bus(1'b1, 10'h118, 16'h0003);
    @(posedge clock_i);
    chk(irq_o, 1'b1);
    bus(1'b1, 10'h110, 16'h0001);
    bus(1'b1, 10'h0e0, 16'h0000);
    bus(1'b1, 10'h0e8, 16'h0000);
    repeat (40) @(posedge clock_i);
    rdc(10'h0e0, 16'h0000);
    foreach (lv[i]) begin
      bus(1'b1, 10'h0f0, {12'h0, lv[i]});
      repeat (2) @(posedge clock_i);
      chk({nvm_cs_o, nvm_clk_o, nvm_serial_in_o, nvm_do_o, nvm_do_oe_o}, {lv[i], !lv[i][3]});
      bus(1'b0, 10'h0f0, 16'h0);
      chk(rdq[0], do_w);
    end
    bus(1'b1, 10'h0f0, 16'h0000);
    host_port_i <= 64'h0123_4567_89ab_cdef;
    host_port_we_i <= 1'b1;
    @(posedge clock_i);
    host_port_we_i <= 1'b0;
    @(posedge clock_i);
    chk(isolated_output_port_o, 64'h0123_4567_89ab_cdef);
    rstn_i <= 1'b0;
    repeat (4) @(posedge clock_i);
    chk({avs_waitrequest_o, irq_o, preset_loaded_o, nvm_cs_o, nvm_clk_o}, 5'h10);
    chk(isolated_output_port_o, 64'h0);
    rstn_i <= 1'b1;
    wait_load();
    chk(isolated_output_port_o, img(0));
    rdc(10'h0d0, 16'hffff);
    rdc(10'h0e0, 16'h0000);
    rdc(10'h110, 16'h0002);
    end_sim;
  end
endmodule : wdps_top_test
`default_nettype wire
